// >>> hw/sms_pkg.sv
// Constants, types and timing for the power-supply mode supervisor.
// Assumes a single 25 MHz clock and comparator decisions made outside.
// How it works
// - 20ms blanking before burst or restart
// - After blanking, release clamp, await pin 4.0V
// - Restart only after further 8.0us filter
// - Blanking timer disabled during soft start
// - Burst fixed blanking; restart adds extension
// - Counter zero normally, counts below 1.35V
// - Burst entry sets flag, bias off
// - Startup cell off during burst
// - Above 3.61V in burst: bias, pulses
// - Burst selects reduced 0.31V current limit
// - At 3.0V in burst: bias off
// - Above 4.5V leaves burst, full limit
// - Fault classes map to latch or restart
// - Latch clears only below 6.23V supply
// - Overvoltage needs supply 24V and feedback 4.5V
// - Latched: startup cell hysteresis, never switching
// - Overtemperature enters latched-off state
// - Thermal and overvoltage pass 8.0us filter
// - Full limit 1.06V; above 1.66V latches
// - External latch ignored 1ms after startup
// - Steep current slope selects earlier threshold
// - Restart blanking starts above 4.5V feedback
// - Short-circuit decision passes 190ns filter
// - Restart retries startup with switching unless thermal or overvoltage latches
package sms_pkg;

  localparam int CLK_HZ          = 25_000_000;
  localparam int CLK_PERIOD_NS   = 40;

  localparam int BLANK_TIME_MS   = 20;
  localparam int LATCH_IGN_MS    = 1;
  localparam int SPIKE_TIME_NS   = 8000;
  localparam int SHORT_FILT_NS   = 190;

  // Exact multiples of the period; filters are least times, so they round up
  localparam int BLANK_CYC_DEF   = BLANK_TIME_MS * (CLK_HZ / 1000);
  localparam int LATCH_IGN_DEF   = LATCH_IGN_MS * (CLK_HZ / 1000);
  localparam int SPIKE_CYC       = (SPIKE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SHORT_CYC       = (SHORT_FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int CNT_W           = 20;
  localparam int FILT_W          = 8;
  localparam int ADDR_W          = 8;
  localparam int DATA_W          = 32;

  localparam logic [ADDR_W-1:0] CTRL_ADDR   = 8'h00;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 8'h04;
  localparam logic [ADDR_W-1:0] CAUSE_ADDR  = 8'h08;

  localparam int CTRL_EXT_LATCH_BIT = 0;
  localparam int CTRL_SLOPE_COMP_BIT = 1;
  localparam logic [1:0] CTRL_RESET = 2'h3;

  typedef enum logic [1:0] {
    SMS_NORMAL,
    SMS_BURST,
    SMS_RESTART,
    SMS_LATCHED
  } sms_mode_t;

  // Current-limit comparator selection driven to the analog section
  typedef enum logic [1:0] {
    SMS_LIM_FULL,
    SMS_LIM_COMP,
    SMS_LIM_BURST
  } sms_lim_t;

  typedef struct packed {
    logic fbBelowBurst;     // feedback_level_comparator, below 1.35V
    logic fbAboveLimit;     // feedback_level_comparator, above 4.5V
    logic fbAboveWake;      // burst_wake_comparator, above 3.61V
    logic fbBelowSleep;     // burst_sleep_comparator, at or below 3.0V
    logic blankPinHigh;     // blank_pin_high_comparator, above 4.0V
    logic blankPinLatchLow; // blanking_pin below 0.1V
    logic vccAboveOvp;      // supply_overvoltage_comparator, above 24V
    logic vccBelowUvlo;     // supply below 10.5V
    logic vccAboveOn;       // supply above 18V
    logic vccBelowReset;    // supply below 6.23V
    logic overTemp;         // above thermal_shutdown_threshold
    logic shortCircuit;     // short_circuit_comparator, above 1.66V
    logic csSlopeSteep;     // current-sense slope detector
  } sms_cmp_t;

  typedef struct packed {
    logic     pwmEnable;
    logic     biasOn;
    logic     startCellOn;
    logic     blankClampOn;
    logic     burstFlag;
    logic     restartActive;
    logic     latchedOff;
    sms_lim_t limitSel;
  } sms_drive_t;

  typedef struct packed {
    logic ovp;
    logic overTemp;
    logic shortCircuit;
    logic extLatch;
  } sms_cause_t;

endpackage : sms_pkg

// >>> hw/sms_spike_filter.sv
// Spike filter: output rises once the input has stood high for CYC clocks.
// Assumes a synchronised input on the same clock; output falls at once.
`timescale 1ns/1ns
`default_nettype none
module sms_spike_filter #(
  parameter int CYC = 1
) (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic ce,
  input  wire logic din,
  output var  logic dout
);
  import sms_pkg::*;

  localparam logic [FILT_W-1:0] LIM = FILT_W'(CYC);

  logic [FILT_W-1:0] cnt_ff;
  logic [FILT_W-1:0] nxt_cnt;
  wire               reached = (cnt_ff == LIM);

  assign nxt_cnt = !din ? '0 : (reached ? cnt_ff : cnt_ff + 8'h01);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_ff <= '0;
      dout   <= 1'b0;
    end else if (ce) begin
      cnt_ff <= nxt_cnt;
      dout   <= din && (nxt_cnt == LIM);
    end
  end

endmodule : sms_spike_filter
`default_nettype wire

// >>> hw/sms_mode_supervisor.sv
// Control-unit state logic: normal, burst, auto restart and latched off.
// Assumes comparator decisions arrive unsynchronised; softStartActive comes
// from the soft-start counter on this clock. Registers on a plain port.
`timescale 1ns/1ns
`default_nettype none
module sms_mode_supervisor #(
  parameter int BLANK_CYC     = sms_pkg::BLANK_CYC_DEF,
  parameter int LATCH_IGN_CYC = sms_pkg::LATCH_IGN_DEF
) (
  input  wire logic                      clk,
  input  wire logic                      nrst,
  input  wire logic                      ce,
  input  wire sms_pkg::sms_cmp_t         cmpIn,
  input  wire logic                      softStartActive,
  input  wire logic [sms_pkg::ADDR_W-1:0] regAddr,
  input  wire logic [sms_pkg::DATA_W-1:0] regWdata,
  input  wire logic                      regWr,
  input  wire logic                      regRd,
  output var  logic [sms_pkg::DATA_W-1:0] regRdata,
  output var  sms_pkg::sms_drive_t       drive
);
  import sms_pkg::*;

  localparam logic [CNT_W-1:0] BLANK_LIM = CNT_W'(BLANK_CYC);
  localparam logic [CNT_W-1:0] IGN_LIM   = CNT_W'(LATCH_IGN_CYC);

  function automatic logic [CNT_W-1:0] satInc(input logic [CNT_W-1:0] v,
                                              input logic [CNT_W-1:0] lim);
    satInc = (v == lim) ? v : v + 20'h0_0001;
  endfunction : satInc

  // Synchroniser; only the second stage is read by any logic
  sms_cmp_t cmpMeta_ff;
  sms_cmp_t cmp_ff;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cmpMeta_ff <= '0;
      cmp_ff     <= '0;
    end else if (ce) begin
      cmpMeta_ff <= cmpIn;
      cmp_ff     <= cmpMeta_ff;
    end
  end

  // State
  sms_mode_t         mode_ff;
  sms_mode_t         nxtMode;
  logic [CNT_W-1:0]  blankCnt_ff;
  logic [CNT_W-1:0]  nxt_blankCnt;
  logic              blankHigh_ff;
  logic              nxt_blankHigh;
  logic [CNT_W-1:0]  ignCnt_ff;
  logic [CNT_W-1:0]  nxt_ignCnt;
  logic              awake_ff;
  logic              nxt_awake;
  logic              cell_ff;
  logic              nxt_cell;
  logic [1:0]        ctrl_ff;
  sms_cause_t        cause_ff;
  sms_cause_t        nxt_cause;
  logic [3:0]        restarts_ff;
  sms_drive_t        nxt_drive;
  logic [DATA_W-1:0] nxt_rdata;

  // Filtered fault decisions
  logic ovpFilt;
  logic otFilt;
  logic scFilt;
  logic restartTrig;

  wire running    = (mode_ff == SMS_NORMAL) || (mode_ff == SMS_BURST);
  wire ovpRaw     = cmp_ff.vccAboveOvp && cmp_ff.fbAboveLimit;
  wire latchArmed = (ignCnt_ff == IGN_LIM);
  wire extLatch   = running && latchArmed && ctrl_ff[CTRL_EXT_LATCH_BIT]
                    && cmp_ff.blankPinLatchLow;
  wire latchFault = ovpFilt || otFilt || scFilt || extLatch;

  // Blanking runs only in normal operation and never during soft start
  wire blankLow   = cmp_ff.fbBelowBurst;
  wire blankHigh  = cmp_ff.fbAboveLimit;
  wire blankRun   = (mode_ff == SMS_NORMAL) && !softStartActive
                    && (blankLow || blankHigh);
  // A change of direction restarts the interval from zero
  wire blankFlip  = blankRun && (blankHigh != blankHigh_ff);
  wire blankDone  = (blankCnt_ff == BLANK_LIM);
  wire burstEntry = blankDone && blankLow && !blankHigh_ff;
  wire clampOpen  = blankDone && blankHigh && blankHigh_ff;
  // Gate combines released clamp, charged pin and persisting overload
  wire restartGate = clampOpen && cmp_ff.blankPinHigh;

  assign nxt_blankCnt  = (!blankRun || blankFlip) ? '0 : satInc(blankCnt_ff, BLANK_LIM);
  assign nxt_blankHigh = blankRun ? blankHigh : 1'b0;

  sms_spike_filter #(
    .CYC (SPIKE_CYC)
  ) uOvpFilt (
    .clk  (clk),
    .nrst (nrst),
    .ce   (ce),
    .din  (ovpRaw),
    .dout (ovpFilt)
  );

  sms_spike_filter #(
    .CYC (SPIKE_CYC)
  ) uOtFilt (
    .clk  (clk),
    .nrst (nrst),
    .ce   (ce),
    .din  (cmp_ff.overTemp),
    .dout (otFilt)
  );

  sms_spike_filter #(
    .CYC (SHORT_CYC)
  ) uScFilt (
    .clk  (clk),
    .nrst (nrst),
    .ce   (ce),
    .din  (cmp_ff.shortCircuit && running),
    .dout (scFilt)
  );

  sms_spike_filter #(
    .CYC (SPIKE_CYC)
  ) uRestartFilt (
    .clk  (clk),
    .nrst (nrst),
    .ce   (ce),
    .din  (restartGate),
    .dout (restartTrig)
  );

  // Mode sequencing; latch faults outrank every other transition
  always_comb begin
    nxtMode = mode_ff;
    unique case (mode_ff)
      SMS_NORMAL: begin
        if (latchFault) begin
          nxtMode = SMS_LATCHED;
        end else if (cmp_ff.vccBelowUvlo || restartTrig) begin
          nxtMode = SMS_RESTART;
        end else if (burstEntry) begin
          nxtMode = SMS_BURST;
        end
      end
      SMS_BURST: begin
        if (latchFault) begin
          nxtMode = SMS_LATCHED;
        end else if (cmp_ff.vccBelowUvlo) begin
          nxtMode = SMS_RESTART;
        end else if (cmp_ff.fbAboveLimit) begin
          nxtMode = SMS_NORMAL;
        end
      end
      SMS_RESTART: begin
        if (otFilt || ovpFilt) begin
          nxtMode = SMS_LATCHED;
        end else if (cmp_ff.vccAboveOn) begin
          // Fresh startup with switching; conditions are rechecked there
          nxtMode = SMS_NORMAL;
        end
      end
      SMS_LATCHED: begin
        if (cmp_ff.vccBelowReset) begin
          nxtMode = SMS_RESTART;
        end
      end
    endcase
  end

  // Burst wake and sleep; entry starts asleep so the bias drops at once
  assign nxt_awake = (nxtMode != SMS_BURST || mode_ff != SMS_BURST) ? 1'b0 :
                     cmp_ff.fbAboveWake  ? 1'b1 :
                     cmp_ff.fbBelowSleep ? 1'b0 :
                     awake_ff;

  // Supply hysteresis for the startup cell: on below 10.5V, off above 18V
  assign nxt_cell = cmp_ff.vccBelowUvlo ? 1'b1 :
                    cmp_ff.vccAboveOn   ? 1'b0 :
                    cell_ff;

  // External latch blanking restarts with every startup phase
  assign nxt_ignCnt = running ? satInc(ignCnt_ff, IGN_LIM) : '0;

  // Fault cause is caught on latch entry and survives until latch release
  assign nxt_cause = (mode_ff == SMS_LATCHED) ?
                       (nxtMode == SMS_RESTART ? '0 : cause_ff) :
                     (nxtMode == SMS_LATCHED) ?
                       sms_cause_t'{ovp: ovpFilt, overTemp: otFilt,
                                    shortCircuit: scFilt, extLatch: extLatch} :
                       cause_ff;

  // Output decode from the next mode, so drive and mode change together
  wire nxtRun     = (nxtMode == SMS_NORMAL) || (nxtMode == SMS_BURST && nxt_awake);
  wire nxtOffMode = (nxtMode == SMS_RESTART) || (nxtMode == SMS_LATCHED);

  assign nxt_drive.pwmEnable     = nxtRun;
  assign nxt_drive.biasOn        = nxtRun;
  assign nxt_drive.startCellOn   = nxtOffMode && nxt_cell;
  assign nxt_drive.blankClampOn  = !(clampOpen && nxtMode == SMS_NORMAL);
  assign nxt_drive.burstFlag     = (nxtMode == SMS_BURST);
  assign nxt_drive.restartActive = (nxtMode == SMS_RESTART);
  assign nxt_drive.latchedOff    = (nxtMode == SMS_LATCHED);
  assign nxt_drive.limitSel      = (nxtMode == SMS_BURST) ? SMS_LIM_BURST :
                                   (ctrl_ff[CTRL_SLOPE_COMP_BIT] && cmp_ff.csSlopeSteep) ?
                                   SMS_LIM_COMP : SMS_LIM_FULL;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mode_ff      <= SMS_RESTART;
      blankCnt_ff  <= '0;
      blankHigh_ff <= 1'b0;
      ignCnt_ff    <= '0;
      awake_ff     <= 1'b0;
      cell_ff      <= 1'b1;
      cause_ff     <= '0;
    end else if (ce) begin
      mode_ff      <= nxtMode;
      blankCnt_ff  <= nxt_blankCnt;
      blankHigh_ff <= nxt_blankHigh;
      ignCnt_ff    <= nxt_ignCnt;
      awake_ff     <= nxt_awake;
      cell_ff      <= nxt_cell;
      cause_ff     <= nxt_cause;
    end
  end

  // Restart attempts since the last latch release, saturating
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      restarts_ff <= '0;
    end else if (ce) begin
      if (mode_ff == SMS_LATCHED) begin
        restarts_ff <= '0;
      end else if (mode_ff == SMS_RESTART && nxtMode == SMS_NORMAL && restarts_ff != 4'hf) begin
        restarts_ff <= restarts_ff + 4'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      drive <= sms_drive_t'{pwmEnable: 1'b0, biasOn: 1'b0, startCellOn: 1'b1,
                            blankClampOn: 1'b1, burstFlag: 1'b0,
                            restartActive: 1'b1, latchedOff: 1'b0,
                            limitSel: SMS_LIM_FULL};
    end else if (ce) begin
      drive <= nxt_drive;
    end
  end

  // Register port: control write, status and cause read
  wire ctrlHit   = (regAddr == CTRL_ADDR);
  wire statusHit = (regAddr == STATUS_ADDR);
  wire causeHit  = (regAddr == CAUSE_ADDR);

  wire [DATA_W-1:0] statusWord = {{(DATA_W-16){1'b0}},
                                  restarts_ff,
                                  latchArmed,
                                  drive.startCellOn,
                                  drive.blankClampOn,
                                  awake_ff,
                                  drive.latchedOff,
                                  drive.restartActive,
                                  drive.burstFlag,
                                  drive.pwmEnable,
                                  drive.limitSel,
                                  mode_ff};

  assign nxt_rdata = !regRd    ? '0 :
                     ctrlHit   ? {{(DATA_W-2){1'b0}}, ctrl_ff} :
                     statusHit ? statusWord :
                     causeHit  ? {{(DATA_W-4){1'b0}}, cause_ff} :
                     '0;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_ff  <= CTRL_RESET;
      regRdata <= '0;
    end else if (ce) begin
      if (regWr && ctrlHit) begin
        ctrl_ff <= regWdata[1:0];
      end
      regRdata <= nxt_rdata;
    end
  end

endmodule : sms_mode_supervisor
`default_nettype wire

// >>> verification/sms_far_side.sv
// Far side: feedback, supply, sense and blanking pin levels in millivolts.
// Assumes the bench sets the levels; this turns them into comparator decisions.
`timescale 1ns/1ns
`default_nettype none
module sms_far_side (
  input  wire logic [15:0]       fbMv,
  input  wire logic [15:0]       vccMv,
  input  wire logic [15:0]       csMv,
  input  wire logic [15:0]       blCapMv,
  input  wire logic              latchPull,
  input  wire logic              hot,
  input  wire logic              steep,
  input  wire logic              clampOn,
  output wire sms_pkg::sms_cmp_t cmp
);
  import sms_pkg::*;
  wire logic [15:0] blMv;
  // The transistor wins over clamp and capacitor alike
  assign blMv = latchPull ? 16'h0032 : (clampOn ? 16'h0384 : blCapMv);
  assign cmp = '{
    fbBelowBurst:     fbMv < 16'h0546,
    fbAboveLimit:     fbMv > 16'h1194,
    fbAboveWake:      fbMv > 16'h0E1A,
    fbBelowSleep:     fbMv <= 16'h0BB8,
    blankPinHigh:     blMv > 16'h0FA0,
    blankPinLatchLow: blMv < 16'h0064,
    vccAboveOvp:      vccMv > 16'h5DC0,
    vccBelowUvlo:     vccMv < 16'h2904,
    vccAboveOn:       vccMv > 16'h4650,
    vccBelowReset:    vccMv < 16'h1856,
    overTemp:         hot,
    shortCircuit:     csMv > 16'h067C,
    csSlopeSteep:     steep
  };
endmodule : sms_far_side
`default_nettype wire

// >>> verification/sms_sup_sva.sv
// Port checker for the mode supervisor.
// Assumes comparator levels reach the logic through two sync stages.
`timescale 1ns/1ns
`default_nettype none
module sms_sup_chk #(
  parameter int BLANK_CYC     = 50,
  parameter int LATCH_IGN_CYC = 20
) (
  input wire logic                       clk,
  input wire logic                       nrst,
  input wire logic                       ce,
  input wire sms_pkg::sms_cmp_t          cmpIn,
  input wire logic                       softStartActive,
  input wire logic [sms_pkg::ADDR_W-1:0] regAddr,
  input wire logic [sms_pkg::DATA_W-1:0] regWdata,
  input wire logic                       regWr,
  input wire logic                       regRd,
  input wire logic [sms_pkg::DATA_W-1:0] regRdata,
  input wire sms_pkg::sms_drive_t        drive
);
  import sms_pkg::*;
  int lowCnt_ff;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) lowCnt_ff <= 0;
    else lowCnt_ff <= cmpIn.fbBelowBurst ? lowCnt_ff + 1 : 0;
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  property p_blank; $rose(drive.burstFlag) |-> lowCnt_ff >= BLANK_CYC; endproperty
  property p_quiet; $rose(drive.burstFlag) |-> !drive.biasOn && !drive.pwmEnable; endproperty
  property p_cell; drive.burstFlag |-> !drive.startCellOn; endproperty
  property p_blim; drive.burstFlag |-> drive.limitSel == SMS_LIM_BURST; endproperty
  property p_full; $fell(drive.burstFlag) && !drive.latchedOff |-> drive.limitSel != SMS_LIM_BURST; endproperty
  property p_dark; drive.latchedOff |-> !drive.pwmEnable; endproperty
  property p_hold;
    $fell(drive.latchedOff) |-> $past(cmpIn.vccBelowReset, 2) || $past(cmpIn.vccBelowReset, 3)
      || $past(cmpIn.vccBelowReset, 4);
  endproperty
  property p_short;
    (!drive.latchedOff && !drive.restartActive) ##0 cmpIn.shortCircuit [*8] |-> ##[1:3] drive.latchedOff;
  endproperty
  a_blank: assert property (p_blank) else $error("burst entered too early");
  a_quiet: assert property (p_quiet) else $error("bias left on at burst entry");
  a_cell: assert property (p_cell) else $error("startup cell on in burst");
  a_blim: assert property (p_blim) else $error("burst without reduced limit");
  a_full: assert property (p_full) else $error("reduced limit kept after burst");
  a_dark: assert property (p_dark) else $error("switching while latched");
  a_hold: assert property (p_hold) else $error("latch released without low supply");
  a_short: assert property (p_short) else $error("short circuit did not latch");
  c_burst: cover property ($rose(drive.burstFlag));
  c_latch: cover property ($rose(drive.latchedOff));
  c_restart: cover property ($rose(drive.restartActive));
endmodule : sms_sup_chk
`default_nettype wire

// >>> verification/sms_mode_supervisor_bench.sv
// Bench for the mode supervisor: far-side model, register port, checker.
// Assumes short blanking and ignore counts; clock enable is dropped once to check the freeze.
`timescale 1ns/1ns
`default_nettype none
module sms_mode_supervisor_bench;
  import sms_pkg::*;
  localparam int BLK = 50;
  localparam int IGN = 20;
  logic        clk, ce, nrst, softStartActive, regWr, regRd, latchPull, hot, steep;
  logic [15:0] fbMv, vccMv, csMv, blCapMv;
  logic [7:0]  regAddr;
  logic [31:0] regWdata, regRdata, d, r, seed;
  sms_cmp_t    cmp;
  sms_drive_t  drive;
  int          err_count, checks, n;
  sms_far_side i_sms_far_side (.fbMv(fbMv), .vccMv(vccMv), .csMv(csMv), .blCapMv(blCapMv),
    .latchPull(latchPull), .hot(hot), .steep(steep), .clampOn(drive.blankClampOn), .cmp(cmp));
  sms_mode_supervisor #(.BLANK_CYC(BLK), .LATCH_IGN_CYC(IGN)) i_sms_mode_supervisor (.clk(clk),
    .nrst(nrst), .ce(ce), .cmpIn(cmp), .softStartActive(softStartActive), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .drive(drive));
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  task automatic end_of_test();
    $display("mismatches %0d of %0d checks", err_count, checks);
    if (err_count == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : end_of_test
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, s);
      err_count++;
    end
  endtask : chk
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : cyc
  // Bounded wait on one drive bit; running out ends the run
  task automatic waitb(input string nm, input int b, input logic v, input int lim, output int k);
    k = 0;
    while (drive[b] !== v && k < lim) begin
      cyc(1);
      k++;
    end
    chk(nm, drive[b], v);
    if (drive[b] !== v) end_of_test();
  endtask : waitb
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    regAddr  <= a;
    regWdata <= v;
    regWr    <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    v = regRdata;
  endtask : rd
  task automatic fset(input logic [15:0] v);
    @(posedge clk);
    fbMv <= v;
  endtask : fset
  task automatic rel(input logic [31:0] cause, input logic p);
    rd(CAUSE_ADDR, d);
    chk("cause", d, cause);
    @(posedge clk);
    vccMv <= 16'h2328;
    fbMv  <= 16'h09C4;
    waitb("cellOn", 6, 1'b1, 10, n);
    @(posedge clk);
    vccMv <= 16'h4A38;
    waitb("cellOff", 6, 1'b0, 10, n);
    cyc(20);
    chk("noStart", drive.pwmEnable, 1'b0);
    chk("held", drive.latchedOff, 1'b1);
    @(posedge clk);
    vccMv <= 16'h1388;
    waitb("unlatch", 2, 1'b0, 10, n);
    rd(CAUSE_ADDR, d);
    chk("causeClr", d, 32'h0000_0000);
    @(posedge clk);
    vccMv     <= 16'h4A38;
    latchPull <= p;
    waitb("retry", 8, 1'b1, 30, n);
  endtask : rel
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    repeat (100000) @(posedge clk);
    err_count++;
    end_of_test();
  end
  initial begin
    {ce, nrst, softStartActive, regWr, regRd, latchPull, hot, steep} = 8'h80;
    {fbMv, vccMv, csMv, blCapMv} = {16'h09C4, 16'h4A38, 16'h01F4, 16'h07D0};
    {regAddr, regWdata, err_count, checks} = '0;
    seed = 32'h0001_38B0;
    cyc(4);
    chk("rstRestart", drive.restartActive, 1'b1);
    nrst <= 1'b1;
    waitb("start", 8, 1'b1, 20, n);
    rd(CTRL_ADDR, d);
    chk("ctrlRst", d, 32'h0000_0003);
    repeat (4) begin
      r = xs();
      wr(CTRL_ADDR, r);
      rd(CTRL_ADDR, d);
      chk("ctrl", d, {30'h0, r[1:0]});
    end
    rd(8'h0C, d);
    chk("unmapped", d, 32'h0000_0000);
    wr(CTRL_ADDR, 32'h0000_0003);
    steep <= 1'b1;
    cyc(6);
    chk("slope", drive.limitSel, SMS_LIM_COMP);
    wr(CTRL_ADDR, 32'h0000_0001);
    cyc(4);
    chk("slopeOff", drive.limitSel, SMS_LIM_FULL);
    wr(CTRL_ADDR, 32'h0000_0003);
    steep <= 1'b0;
    repeat (40) begin
      fset(16'h0578 + 16'(xs() % 32'd8000 / 32'd3));
      cyc(2);
    end
    chk("randNormal", {drive.burstFlag, drive.pwmEnable}, 2'b01);
    // Undervoltage while frozen must not move the mode until the enable returns
    @(posedge clk);
    ce    <= 1'b0;
    vccMv <= 16'h2328;
    cyc(10);
    chk("ceFreeze", drive.restartActive, 1'b0);
    @(posedge clk);
    ce <= 1'b1;
    waitb("ceRun", 3, 1'b1, 10, n);
    @(posedge clk);
    vccMv <= 16'h4A38;
    waitb("ceBack", 8, 1'b1, 30, n);
    @(posedge clk);
    softStartActive <= 1'b1;
    fbMv            <= 16'h03E8;
    cyc(3 * BLK);
    chk("softHold", drive.burstFlag, 1'b0);
    @(posedge clk);
    softStartActive <= 1'b0;
    cyc(BLK / 2);
    chk("early", drive.burstFlag, 1'b0);
    waitb("burst", 4, 1'b1, BLK, n);
    chk("burstBias", {drive.biasOn, drive.startCellOn, drive.limitSel}, {2'b00, SMS_LIM_BURST});
    // Asleep in burst, clamp held, latch armed, two startups since reset
    rd(STATUS_ADDR, d);
    chk("status", d, 32'h0000_2A29);
    fset(16'h0E74);
    waitb("wake", 8, 1'b1, 8, n);
    fset(16'h0B54);
    waitb("sleep", 7, 1'b0, 8, n);
    fset(16'h125C);
    waitb("leave", 4, 1'b0, 8, n);
    fset(16'h09C4);
    cyc(2);
    chk("fullLim", drive.limitSel === SMS_LIM_BURST, 1'b0);
    fset(16'h125C);
    waitb("clampOff", 5, 1'b0, BLK + 10, n);
    cyc(300);
    chk("extBlank", drive.restartActive, 1'b0);
    @(posedge clk);
    blCapMv <= 16'h1194;
    waitb("restart", 3, 1'b1, 220, n);
    chk("spike", n >= 200, 1'b1);
    @(posedge clk);
    fbMv    <= 16'h09C4;
    blCapMv <= 16'h07D0;
    waitb("resume", 8, 1'b1, 30, n);
    @(posedge clk);
    vccMv <= 16'h61A8;
    cyc(300);
    chk("ovpAlone", drive.latchedOff, 1'b0);
    fset(16'h125C);
    waitb("ovp", 2, 1'b1, 220, n);
    chk("ovpFilt", n >= 200, 1'b1);
    rel(32'h0000_0008, 1'b0);
    @(posedge clk);
    csMv <= 16'h0708;
    @(posedge clk);
    csMv <= 16'h01F4;
    cyc(10);
    chk("shortPulse", drive.latchedOff, 1'b0);
    @(posedge clk);
    csMv <= 16'h0708;
    waitb("short", 2, 1'b1, 12, n);
    @(posedge clk);
    csMv <= 16'h01F4;
    rel(32'h0000_0002, 1'b0);
    @(posedge clk);
    hot <= 1'b1;
    cyc(100);
    @(posedge clk);
    hot <= 1'b0;
    cyc(10);
    chk("hotPulse", drive.latchedOff, 1'b0);
    @(posedge clk);
    hot <= 1'b1;
    waitb("hot", 2, 1'b1, 220, n);
    chk("hotFilt", n >= 200, 1'b1);
    @(posedge clk);
    hot <= 1'b0;
    rel(32'h0000_0004, 1'b0);
    wr(CTRL_ADDR, 32'h0000_0002);
    latchPull <= 1'b1;
    cyc(IGN + 10);
    chk("extOff", drive.latchedOff, 1'b0);
    wr(CTRL_ADDR, 32'h0000_0003);
    waitb("ext", 2, 1'b1, 10, n);
    rel(32'h0000_0001, 1'b1);
    chk("extIgnore", drive.latchedOff, 1'b0);
    waitb("extLate", 2, 1'b1, IGN + 10, n);
    chk("extWait", n >= IGN - 5, 1'b1);
    end_of_test();
  end
endmodule : sms_mode_supervisor_bench
bind sms_mode_supervisor sms_sup_chk #(.BLANK_CYC(BLANK_CYC), .LATCH_IGN_CYC(LATCH_IGN_CYC)) i_sms_sup_chk (
  .clk(clk), .nrst(nrst), .ce(ce), .cmpIn(cmpIn), .softStartActive(softStartActive), .regAddr(regAddr),
  .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .drive(drive));
`default_nettype wire
